// >>> rtl/sd_adc_pkg.sv
package sd_adc_pkg;

  // Sample clock enable: one tick every this many master clock cycles
  localparam int SAMPLE_DIVIDE = 25;
  localparam int DIV_WIDTH     = 5;

  // Filter block length is BASE_BLOCK shifted left by the rate code, capped at RATE_MAX
  localparam int            BASE_BLOCK  = 125;
  localparam int            CNT_WIDTH   = 13;
  localparam logic [2:0]    RATE_MAX    = 3'h6;
  localparam logic signed [23:0] SCALE_FACTOR = 24'sh00007d;
  localparam logic signed [23:0] RESULT_LIMIT = 24'sh003d09;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_INTERRUPT_FLAGS   = 6'h06;
  localparam logic [5:0] IDX_INTERRUPT_ENABLES = 6'h07;
  localparam logic [5:0] IDX_RESULT_HIGH_BYTE  = 6'h10;
  localparam logic [5:0] IDX_RESULT_LOW_BYTE   = 6'h11;
  localparam logic [5:0] IDX_CONVERTER_CONTROL = 6'h13;
  localparam logic [5:0] IDX_INPUT_PATH_SELECT = 6'h2a;
  localparam logic [5:0] IDX_REFERENCE_SELECT  = 6'h2c;
  localparam logic [5:0] IDX_GAIN_AND_ENABLE   = 6'h2f;

  // Writable bits of each register
  localparam logic [7:0] MASK_INTERRUPT_ENABLES = 8'h82;
  localparam logic [7:0] MASK_CONVERTER_CONTROL = 8'h0f;
  localparam logic [7:0] MASK_INPUT_PATH_SELECT = 8'h7d;
  localparam logic [7:0] MASK_REFERENCE_SELECT  = 8'h70;
  localparam logic [7:0] MASK_GAIN_AND_ENABLE   = 8'h0f;

  // Reset values
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_RESULT = 16'h0000;

  // Field positions
  localparam int FLAG_DONE_BIT      = 1;
  localparam int EN_CONV_BIT        = 1;
  localparam int EN_GLOBAL_BIT      = 7;
  localparam int CTRL_RUN_BIT       = 3;
  localparam int CTRL_RATE_LSB      = 0;
  localparam int PATH_DIRECT_BIT    = 0;
  localparam int PATH_LOWPASS_BIT   = 2;
  localparam int PATH_POS_LSB       = 3;
  localparam int PATH_NEG_LSB       = 5;
  localparam int REF_LOW_LSB        = 4;
  localparam int REF_HIGH_BIT       = 6;
  localparam int GAIN_AZ_BIT        = 0;
  localparam int GAIN_MOD_EN_BIT    = 1;
  localparam int GAIN_SEL_LSB       = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/sigma_delta_adc_control.sv
`timescale 1ns/1ps
`default_nettype none

module sigma_delta_adc_control #(
  parameter int SAMPLE_DIVIDE = sd_adc_pkg::SAMPLE_DIVIDE
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Modulator bitstream and control
  input  wire logic       modulator_bit,
  output logic            modulator_enable,
  output logic            sample_clock,
  output logic            auto_zero,
  output logic [1:0]      input_gain_select,
  // Input and reference multiplexers
  output logic [1:0]      positive_source_select,
  output logic            lowpass_enable,
  output logic            positive_input_direct,
  output logic [1:0]      negative_source_select,
  output logic            reference_high_select,
  output logic [1:0]      reference_low_select,
  // Interrupt to the CPU
  output logic            conversion_irq
);

  // Block length for a rate code; codes above the last repeat it
  function automatic logic [sd_adc_pkg::CNT_WIDTH-1:0] block_length(input logic [2:0] rate);
    logic [2:0] r;
    r = (rate > sd_adc_pkg::RATE_MAX) ? sd_adc_pkg::RATE_MAX : rate;
    block_length = sd_adc_pkg::CNT_WIDTH'(sd_adc_pkg::BASE_BLOCK) << r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  interrupt_enables;
  logic [7:0]  converter_control;
  logic [7:0]  input_path_select;
  logic [7:0]  reference_select;
  logic [7:0]  gain_and_enable;
  logic        conversion_done_flag;
  logic [15:0] conversion_result;

  // Field views
  wire       filter_run  = converter_control[sd_adc_pkg::CTRL_RUN_BIT];
  wire [2:0] output_rate_select = converter_control[sd_adc_pkg::CTRL_RATE_LSB +: 3];
  wire       global_irq_enable  = interrupt_enables[sd_adc_pkg::EN_GLOBAL_BIT];
  wire       conversion_irq_enable = interrupt_enables[sd_adc_pkg::EN_CONV_BIT];

  // Front-end controls straight from register flip-flops
  assign modulator_enable       = gain_and_enable[sd_adc_pkg::GAIN_MOD_EN_BIT];
  assign auto_zero              = gain_and_enable[sd_adc_pkg::GAIN_AZ_BIT];
  assign input_gain_select      = gain_and_enable[sd_adc_pkg::GAIN_SEL_LSB +: 2];
  assign positive_source_select = input_path_select[sd_adc_pkg::PATH_POS_LSB +: 2];
  assign lowpass_enable         = input_path_select[sd_adc_pkg::PATH_LOWPASS_BIT];
  assign positive_input_direct  = input_path_select[sd_adc_pkg::PATH_DIRECT_BIT];
  assign negative_source_select = input_path_select[sd_adc_pkg::PATH_NEG_LSB +: 2];
  assign reference_high_select  = reference_select[sd_adc_pkg::REF_HIGH_BIT];
  assign reference_low_select   = reference_select[sd_adc_pkg::REF_LOW_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock divider
  logic [sd_adc_pkg::DIV_WIDTH-1:0] div_cnt;
  wire div_wrap = (div_cnt == sd_adc_pkg::DIV_WIDTH'(SAMPLE_DIVIDE - 1));

  // One tick every SAMPLE_DIVIDE cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt      <= '0;
      sample_clock <= 1'b0;
    end else begin
      div_cnt      <= div_wrap ? '0 : div_cnt + 1'b1;
      sample_clock <= div_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bitstream synchroniser
  logic mod_meta;
  logic mod_sync;

  // Two stages before the filter looks at the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_meta <= 1'b0;
      mod_sync <= 1'b0;
    end else begin
      mod_meta <= modulator_bit;
      mod_sync <= mod_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comb filter: ones count over two consecutive blocks
  logic [sd_adc_pkg::CNT_WIDTH-1:0] samp_cnt;
  logic [sd_adc_pkg::CNT_WIDTH-1:0] ones;
  logic [sd_adc_pkg::CNT_WIDTH-1:0] prev_ones;
  logic                             primed;

  // Block bookkeeping
  wire [sd_adc_pkg::CNT_WIDTH-1:0] block_len = block_length(output_rate_select);
  wire advance   = sample_clock && filter_run && modulator_enable;
  wire block_end = advance && (samp_cnt >= block_len - 1'b1);
  wire block_done = block_end && primed;
  wire [sd_adc_pkg::CNT_WIDTH-1:0] ones_now = ones + {{(sd_adc_pkg::CNT_WIDTH-1){1'b0}}, mod_sync};

  // Scaling: (ones - N) * 15625 / N over 2N samples
  wire [2:0] rate_shift = (output_rate_select > sd_adc_pkg::RATE_MAX) ?
                          sd_adc_pkg::RATE_MAX : output_rate_select;
  wire [13:0] total = {1'b0, prev_ones} + {1'b0, ones_now};
  wire signed [14:0] diff = $signed({1'b0, total}) - $signed({2'b00, block_len});
  wire signed [23:0] product = $signed({{9{diff[14]}}, diff}) * sd_adc_pkg::SCALE_FACTOR;
  wire signed [23:0] scaled = product >>> rate_shift;
  wire signed [23:0] clamped = (scaled > sd_adc_pkg::RESULT_LIMIT) ? sd_adc_pkg::RESULT_LIMIT :
                               (scaled < -sd_adc_pkg::RESULT_LIMIT) ? -sd_adc_pkg::RESULT_LIMIT :
                               scaled;
  wire [15:0] next_result = clamped[15:0];

  // Filter held clear while not running
  always_ff @(posedge aclk) begin
    if (!aresetn || !filter_run) begin
      samp_cnt  <= '0;
      ones      <= '0;
      prev_ones <= '0;
      primed    <= 1'b0;
    end else if (block_end) begin
      samp_cnt  <= '0;
      ones      <= '0;
      prev_ones <= ones_now;
      primed    <= 1'b1;
    end else if (advance) begin
      samp_cnt  <= samp_cnt + 1'b1;
      ones      <= ones_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  logic       aw_full;
  logic       w_full;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_low_lane;

  // Write takes effect once address and data are both held
  wire       do_write = aw_full && w_full && !s_axi_bvalid;
  wire [5:0] wr_idx   = aw_addr[7:2];
  wire       wr_en    = do_write && w_low_lane;
  wire wr_flags  = wr_en && (wr_idx == sd_adc_pkg::IDX_INTERRUPT_FLAGS);
  wire wr_enable = wr_en && (wr_idx == sd_adc_pkg::IDX_INTERRUPT_ENABLES);
  wire wr_ctrl   = wr_en && (wr_idx == sd_adc_pkg::IDX_CONVERTER_CONTROL);
  wire wr_path   = wr_en && (wr_idx == sd_adc_pkg::IDX_INPUT_PATH_SELECT);
  wire wr_ref    = wr_en && (wr_idx == sd_adc_pkg::IDX_REFERENCE_SELECT);
  wire wr_gain   = wr_en && (wr_idx == sd_adc_pkg::IDX_GAIN_AND_ENABLE);
  wire wr_mapped = (wr_idx == sd_adc_pkg::IDX_INTERRUPT_FLAGS) ||
                   (wr_idx == sd_adc_pkg::IDX_INTERRUPT_ENABLES) ||
                   (wr_idx == sd_adc_pkg::IDX_RESULT_HIGH_BYTE) ||
                   (wr_idx == sd_adc_pkg::IDX_RESULT_LOW_BYTE) ||
                   (wr_idx == sd_adc_pkg::IDX_CONVERTER_CONTROL) ||
                   (wr_idx == sd_adc_pkg::IDX_INPUT_PATH_SELECT) ||
                   (wr_idx == sd_adc_pkg::IDX_REFERENCE_SELECT) ||
                   (wr_idx == sd_adc_pkg::IDX_GAIN_AND_ENABLE);
  wire flag_clear = wr_flags && !w_byte[sd_adc_pkg::FLAG_DONE_BIT];
  wire b_done = s_axi_bvalid && s_axi_bready;

  // Address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      aw_addr       <= sd_adc_pkg::RESET_BYTE;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (b_done || !aw_full) begin
      aw_full       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Data channel, low lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full       <= 1'b0;
      w_byte       <= sd_adc_pkg::RESET_BYTE;
      w_low_lane   <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full       <= 1'b1;
      w_byte       <= s_axi_wdata[7:0];
      w_low_lane   <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (b_done || !w_full) begin
      w_full       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Response after both channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sd_adc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? sd_adc_pkg::RESP_OKAY : sd_adc_pkg::RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_enables <= sd_adc_pkg::RESET_BYTE;
      converter_control <= sd_adc_pkg::RESET_BYTE;
      input_path_select <= sd_adc_pkg::RESET_BYTE;
      reference_select  <= sd_adc_pkg::RESET_BYTE;
      gain_and_enable   <= sd_adc_pkg::RESET_BYTE;
    end else begin
      if (wr_enable) interrupt_enables <= w_byte & sd_adc_pkg::MASK_INTERRUPT_ENABLES;
      if (wr_ctrl) converter_control <= w_byte & sd_adc_pkg::MASK_CONVERTER_CONTROL;
      if (wr_path) input_path_select <= w_byte & sd_adc_pkg::MASK_INPUT_PATH_SELECT;
      if (wr_ref) reference_select <= w_byte & sd_adc_pkg::MASK_REFERENCE_SELECT;
      if (wr_gain) gain_and_enable <= w_byte & sd_adc_pkg::MASK_GAIN_AND_ENABLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result, flag and interrupt
  wire next_flag = block_done || (conversion_done_flag && !flag_clear);

  // Result loads whole; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_result    <= sd_adc_pkg::RESET_RESULT;
      conversion_done_flag <= 1'b0;
      conversion_irq       <= 1'b0;
    end else begin
      if (block_done) conversion_result <= next_result;
      conversion_done_flag <= next_flag;
      conversion_irq <= conversion_done_flag && conversion_irq_enable && global_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  logic [7:0] rd_value;
  logic       rd_hit;

  // Read decode
  always_comb begin
    rd_value = sd_adc_pkg::RESET_BYTE;
    rd_hit   = 1'b1;
    if (rd_idx == sd_adc_pkg::IDX_INTERRUPT_FLAGS) begin
      rd_value[sd_adc_pkg::FLAG_DONE_BIT] = conversion_done_flag;
    end else if (rd_idx == sd_adc_pkg::IDX_INTERRUPT_ENABLES) begin
      rd_value = interrupt_enables;
    end else if (rd_idx == sd_adc_pkg::IDX_RESULT_HIGH_BYTE) begin
      rd_value = conversion_result[15:8];
    end else if (rd_idx == sd_adc_pkg::IDX_RESULT_LOW_BYTE) begin
      rd_value = conversion_result[7:0];
    end else if (rd_idx == sd_adc_pkg::IDX_CONVERTER_CONTROL) begin
      rd_value = converter_control;
    end else if (rd_idx == sd_adc_pkg::IDX_INPUT_PATH_SELECT) begin
      rd_value = input_path_select;
    end else if (rd_idx == sd_adc_pkg::IDX_REFERENCE_SELECT) begin
      rd_value = reference_select;
    end else if (rd_idx == sd_adc_pkg::IDX_GAIN_AND_ENABLE) begin
      rd_value = gain_and_enable;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read handshake, one answer per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= sd_adc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_value};
      s_axi_rresp   <= rd_hit ? sd_adc_pkg::RESP_OKAY : sd_adc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence done_event;
    block_done ##1 1'b1;
  endsequence

  sequence flag_zero_write;
    flag_clear && !block_done;
  endsequence

  result_range_a: assert property (
    $signed(conversion_result) <= sd_adc_pkg::RESULT_LIMIT &&
    $signed(conversion_result) >= -sd_adc_pkg::RESULT_LIMIT)
    else $error("result outside clamp range");

  result_sign_a: assert property (
    block_done && diff < 0 |=> conversion_result[15])
    else $error("negative code lost its sign bit");

  result_pair_a: assert property (
    !$stable(conversion_result) |-> $past(block_done))
    else $error("result changed without a new code");

  flag_set_a: assert property (
    done_event |-> conversion_done_flag)
    else $error("new code did not raise the flag");

  flag_clear_a: assert property (
    conversion_done_flag && !flag_clear |=> conversion_done_flag)
    else $error("flag dropped without a zero write");

  flag_zero_a: assert property (
    flag_zero_write |=> !conversion_done_flag)
    else $error("zero write did not clear the flag");

  filter_hold_a: assert property (
    !filter_run |=> samp_cnt == '0 && ones == '0 && !primed)
    else $error("filter not held while stopped");

  modulator_stop_a: assert property (
    !modulator_enable && filter_run |=> $stable(samp_cnt) && $stable(ones))
    else $error("filter advanced with modulator stopped");

  block_size_a: assert property (
    block_end |-> samp_cnt == block_len - 1'b1)
    else $error("block ended at wrong sample count");

  tick_space_a: assert property (
    sample_clock |=> !sample_clock [*8])
    else $error("sample ticks too close together");

  irq_gate_a: assert property (
    conversion_irq |-> $past(conversion_done_flag && conversion_irq_enable && global_irq_enable))
    else $error("interrupt raised without both enables");

endmodule

`default_nettype wire

// >>> test/modulator_model.sv
`timescale 1ns/1ps
`default_nettype none

module modulator_model (
  // Clock and converter strobes
  input  wire logic aclk,
  input  wire logic sample_clock,
  input  wire logic modulator_enable,
  input  wire logic auto_zero,
  // Bench control: 1 drives full scale up, 0 full scale down
  input  wire logic polarity,
  // Bitstream into the converter
  output var  logic modulator_bit
);
  initial modulator_bit = 1'b0;

  // Steps only on sample ticks; a stopped modulator leaves a toggling line
  always @(posedge aclk) begin
    if (!modulator_enable) begin
      modulator_bit <= ~modulator_bit;
    end else if (sample_clock) begin
      modulator_bit <= auto_zero ? ~modulator_bit : polarity;
    end
  end
endmodule

`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [3:0]  wstrb = 4'h1;
  logic        polarity = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, modulator_bit;
  logic [1:0]  bresp, rresp, input_gain_select, positive_source_select;
  logic [1:0]  negative_source_select, reference_low_select;
  logic [31:0] rdata;
  logic        modulator_enable, sample_clock, auto_zero, lowpass_enable;
  logic        positive_input_direct, reference_high_select, conversion_irq;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t_prev = 0;
  int          t_last = 0;

  // Clock and free cycle count
  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  sigma_delta_adc_control dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .modulator_bit(modulator_bit), .modulator_enable(modulator_enable),
    .sample_clock(sample_clock), .auto_zero(auto_zero), .input_gain_select(input_gain_select),
    .positive_source_select(positive_source_select), .lowpass_enable(lowpass_enable),
    .positive_input_direct(positive_input_direct),
    .negative_source_select(negative_source_select),
    .reference_high_select(reference_high_select), .reference_low_select(reference_low_select),
    .conversion_irq(conversion_irq)
  );

  modulator_model partner (
    .aclk(aclk), .sample_clock(sample_clock), .modulator_enable(modulator_enable),
    .auto_zero(auto_zero), .polarity(polarity), .modulator_bit(modulator_bit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus cycles
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = sd_adc_pkg::RESP_OKAY);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write resp", {14'h0000, er}, {14'h0000, bresp});
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp,
                    input logic [1:0] er = sd_adc_pkg::RESP_OKAY);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("read data", {8'h00, exp}, rdata[15:0]);
    chk("read upper", 16'h0000, rdata[31:16]);
    chk("read resp", {14'h0000, er}, {14'h0000, rresp});
  endtask

  // Clears the done flag, then waits for the next code on the interrupt line
  task automatic next_code();
    int k;
    k = 0;
    wr(sd_adc_pkg::IDX_INTERRUPT_FLAGS, 8'h00);
    @(posedge aclk);
    while (conversion_irq !== 1'b1 && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    t_prev = t_last;
    t_last = cyc;
    chk("code arrived", 16'h0001, {15'h0000, conversion_irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (95000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end

  // Test sequence
  initial begin
    logic [1:0] v;
    int         k;
    int         t0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sd_adc_pkg::IDX_INTERRUPT_FLAGS, 8'h00);
    rd(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'h00);
    rd(sd_adc_pkg::IDX_RESULT_LOW_BYTE, 8'h00);
    rd(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h00);
    rd(sd_adc_pkg::IDX_INPUT_PATH_SELECT, 8'h00);
    rd(sd_adc_pkg::IDX_GAIN_AND_ENABLE, 8'h00);
    rd(6'h00, 8'h00, sd_adc_pkg::RESP_SLVERR);
    wr(6'h01, 8'hff, sd_adc_pkg::RESP_SLVERR);
    wr(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'hff);
    rd(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'h00);
    // Low lane strobe off: write must not land
    wstrb <= 4'h0;
    wr(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h0f);
    wstrb <= 4'h1;
    rd(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h00);
    // Every code of each select field, seen on the pins and read back
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      wr(sd_adc_pkg::IDX_INPUT_PATH_SELECT, {1'b0, v, v, v[1], 1'b0, v[0]});
      wr(sd_adc_pkg::IDX_REFERENCE_SELECT, {1'b0, v[0], v, 4'h0});
      wr(sd_adc_pkg::IDX_GAIN_AND_ENABLE, {4'h0, v, v});
      rd(sd_adc_pkg::IDX_INPUT_PATH_SELECT, {1'b0, v, v, v[1], 1'b0, v[0]});
      rd(sd_adc_pkg::IDX_REFERENCE_SELECT, {1'b0, v[0], v, 4'h0});
      rd(sd_adc_pkg::IDX_GAIN_AND_ENABLE, {4'h0, v, v});
      chk("sources", {12'h000, v, v}, {12'h000, negative_source_select, positive_source_select});
      chk("filter path", {14'h0000, v}, {14'h0000, lowpass_enable, positive_input_direct});
      chk("references", {13'h0000, v[0], v}, {13'h0000, reference_high_select, reference_low_select});
      chk("gain pins", {12'h000, v, v}, {12'h000, input_gain_select, modulator_enable, auto_zero});
    end
    // Sample tick period
    k = 0;
    while (sample_clock !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    while (sample_clock !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
    end
    chk("sample period", 16'h0019, 16'(k + 1));
    // Full scale up: clamp, byte pairing, first code after two blocks
    wr(sd_adc_pkg::IDX_INTERRUPT_ENABLES, 8'h82);
    wr(sd_adc_pkg::IDX_GAIN_AND_ENABLE, 8'h02);
    wr(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h08);
    t0 = cyc;
    next_code();
    chk("first code", 16'h0001, {15'h0000, (t_last - t0 >= 6225 && t_last - t0 <= 6300)});
    repeat (2) next_code();
    rd(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'h3d);
    rd(sd_adc_pkg::IDX_RESULT_LOW_BYTE, 8'h09);
    next_code();
    chk("code interval", 16'h0c35, 16'(t_last - t_prev));
    // Global enable masks the line while the flag stays set
    wr(sd_adc_pkg::IDX_INTERRUPT_ENABLES, 8'h02);
    repeat (3) @(posedge aclk);
    chk("masked irq", 16'h0000, {15'h0000, conversion_irq});
    rd(sd_adc_pkg::IDX_INTERRUPT_FLAGS, 8'h02);
    wr(sd_adc_pkg::IDX_INTERRUPT_ENABLES, 8'h82);
    repeat (3) @(posedge aclk);
    chk("unmasked irq", 16'h0001, {15'h0000, conversion_irq});
    // Full scale down, then the input shorted
    polarity <= 1'b0;
    repeat (3) next_code();
    rd(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'hc2);
    rd(sd_adc_pkg::IDX_RESULT_LOW_BYTE, 8'hf7);
    polarity <= 1'b1;
    wr(sd_adc_pkg::IDX_GAIN_AND_ENABLE, 8'h03);
    repeat (3) next_code();
    rd(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'h00);
    rd(sd_adc_pkg::IDX_RESULT_LOW_BYTE, 8'h00);
    // Second rate code doubles the block
    wr(sd_adc_pkg::IDX_GAIN_AND_ENABLE, 8'h02);
    wr(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h09);
    repeat (4) next_code();
    chk("rate 1 interval", 16'h186a, 16'(t_last - t_prev));
    // Filter held, then modulator stopped: no codes
    wr(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h01);
    wr(sd_adc_pkg::IDX_INTERRUPT_FLAGS, 8'h00);
    repeat (7000) @(posedge aclk);
    rd(sd_adc_pkg::IDX_INTERRUPT_FLAGS, 8'h00);
    wr(sd_adc_pkg::IDX_GAIN_AND_ENABLE, 8'h00);
    wr(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h08);
    chk("modulator off", 16'h0000, {15'h0000, modulator_enable});
    repeat (7000) @(posedge aclk);
    rd(sd_adc_pkg::IDX_INTERRUPT_FLAGS, 8'h00);
    // Mid-run reset clears the held result and the control bits
    rd(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'h3d);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sd_adc_pkg::IDX_RESULT_HIGH_BYTE, 8'h00);
    rd(sd_adc_pkg::IDX_RESULT_LOW_BYTE, 8'h00);
    rd(sd_adc_pkg::IDX_CONVERTER_CONTROL, 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
